//--- hdl/bcd_display_map.svh
// Register offsets, field positions, reset values and counts for the BCD counter display driver.
// Assumes inclusion by bare name from files that need the register map.
`ifndef BCD_DISPLAY_MAP_SVH
`define BCD_DISPLAY_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTRL_OFFSET        12'h000
`define STATUS_OFFSET      12'h004

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_PAR_EN_N_BIT  0
`define CTRL_SER_EN_N_BIT  1
`define CTRL_CLEAR_N_BIT   2
`define CTRL_HOLD_BIT      3
`define CTRL_BLANK_BIT     4
`define CTRL_ZB_IN_N_BIT   5
`define CTRL_POINT_BIT     6
`define CTRL_WIDTH         7
`define CTRL_RESET         7'h27

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define STAT_COUNT_LSB     0
`define STAT_LATCH_LSB     4
`define STAT_MAXCNT_BIT    8
`define STAT_NODE_BIT      9
`define STAT_SEG_LSB       10
`define STAT_POINT_BIT     17

// ----------------------------------------------------------------
// Counter and bus constants
// ----------------------------------------------------------------
`define COUNT_ZERO         4'h0
`define COUNT_MAX          4'h9
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

//--- hdl/bcd_display_pkg.sv
// Types shared by the BCD counter display driver and its segment decoder.
// Assumes the register map header is compiled alongside.
package bcd_display_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [3:0] digit_t;
  typedef logic [6:0] segments_t;

  typedef enum logic [2:0] {
    SEL_CTRL   = 3'b001,
    SEL_STATUS = 3'b010,
    SEL_NONE   = 3'b100
  } reg_sel_t;

endpackage : bcd_display_pkg

//--- hdl/segment_if.sv
// Carrier between the counter core and the segment decoder.
// Assumes both ends share aclk.
`timescale 1ns/1ps
interface segment_if;
  import bcd_display_pkg::*;

  digit_t    value;
  logic      blank;
  logic      point;
  segments_t seg_n;
  logic      point_n;

  modport core    (output value, output blank, output point, input seg_n, input point_n);
  modport decoder (input value, input blank, input point, output seg_n, output point_n);

endinterface : segment_if

//--- hdl/segment_decoder.sv
// Registered seven-segment decoder with decimal point and blanking, active-low outputs.
// Assumes inputs come from logic on aclk.
`timescale 1ns/1ps
module segment_decoder
  import bcd_display_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  segment_if.decoder link
);

  // ----------------------------------------------------------------
  // Digit shapes, bit 0 is segment a
  // ----------------------------------------------------------------
  function automatic segments_t digit_shape(input digit_t value);
    case (value)
      4'h0:    digit_shape = 7'h3f;
      4'h1:    digit_shape = 7'h06;
      4'h2:    digit_shape = 7'h5b;
      4'h3:    digit_shape = 7'h4f;
      4'h4:    digit_shape = 7'h66;
      4'h5:    digit_shape = 7'h6d;
      4'h6:    digit_shape = 7'h7d;
      4'h7:    digit_shape = 7'h07;
      4'h8:    digit_shape = 7'h7f;
      4'h9:    digit_shape = 7'h6f;
      default: digit_shape = 7'h00;
    endcase
  endfunction : digit_shape

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.seg_n <= 7'h7f;
    end else if (link.blank) begin
      link.seg_n <= 7'h7f;
    end else begin
      link.seg_n <= ~digit_shape(link.value);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.point_n <= 1'b1;
    end else begin
      link.point_n <= ~(link.point & ~link.blank);
    end
  end

endmodule : segment_decoder

//--- hdl/bcd_counter_latch_segment_driver.sv
// BCD decade counter with latch, seven-segment driver and AXI4-Lite control.
// Assumes an external pull-up on the zero-blank node and a common-anode display.
//
// Notes on behaviour
// - Clear low forces counter to zero.
// - Count up when both enables low.
// - Parallel enable high holds the count.
// - Serial enable high inhibits, terminal output high.
// - Terminal output low at nine, serial low.
// - Decade wrap nine to zero.
// - Terminal output high for zero through eight.
// - Latch follows counter unless hold set.
// - Latched value out, weights one to eight.
// - Point lit only when requested, unblanked.
// - Blank input darkens all, pulls node low.
// - Zero latched, zero-blank in low blanks.
// - Node low on blank or rippled zero.
// - Node low from anywhere blanks display.
// - Seven segments from latch, point from control.
`timescale 1ns/1ps
`include "bcd_display_map.svh"
module bcd_counter_latch_segment_driver
  import bcd_display_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output      logic [6:0]        seg_n,
  output      logic              point_segment_out,
  output      logic              bcd_out_weight1,
  output      logic              bcd_out_weight2,
  output      logic              bcd_out_weight4,
  output      logic              bcd_out_weight8,
  output      logic              max_count_n,
  input  wire logic              zero_blank_node_n_level,
  output      logic              zero_blank_node_n_drive,
  output      logic              zero_blank_node_n_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`CTRL_WIDTH-1:0] ctrl;
  digit_t                 count;
  digit_t                 latched;
  logic                   node_meta;
  logic                   node_sync;
  logic                   aw_done;
  logic                   w_done;
  logic [ADDR_W-1:0]      aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_hold_latch;
  logic                   write_commit;
  reg_sel_t               write_sel;
  logic                   parallel_count_enable_n;
  logic                   serial_count_enable_n;
  logic                   direct_clear_n;
  logic                   hold_latch;
  logic                   blank_all;
  logic                   zero_blank_in_n;
  logic                   point_in;
  logic                   zero_blank_out_n;
  logic                   display_blank;
  logic                   blank_q;
  segment_if              seg_link ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`CTRL_OFFSET >> 2)) begin
      decode_addr = SEL_CTRL;
    end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`STATUS_OFFSET >> 2)) begin
      decode_addr = SEL_STATUS;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction : decode_addr

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign parallel_count_enable_n = ctrl[`CTRL_PAR_EN_N_BIT];
  assign serial_count_enable_n   = ctrl[`CTRL_SER_EN_N_BIT];
  assign direct_clear_n          = ctrl[`CTRL_CLEAR_N_BIT];
  assign hold_latch              = ctrl[`CTRL_HOLD_BIT];
  assign blank_all               = ctrl[`CTRL_BLANK_BIT];
  assign zero_blank_in_n         = ctrl[`CTRL_ZB_IN_N_BIT];
  assign point_in                = ctrl[`CTRL_POINT_BIT];

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign write_commit = aw_done & w_done & ~s_axi_bvalid;
  assign write_sel    = decode_addr(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_done       <= 1'b0;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_done       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (write_commit) begin
      aw_done       <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_done       <= 1'b0;
      w_data       <= '0;
      w_hold_latch       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_done       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_hold_latch       <= s_axi_wstrb;
    end else if (write_commit) begin
      w_done       <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (write_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (write_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CTRL_RESET;
    end else if (write_commit && write_sel == SEL_CTRL && w_hold_latch[0]) begin
      ctrl <= w_data[`CTRL_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      case (decode_addr(s_axi_araddr))
        SEL_CTRL: begin
          s_axi_rdata[`CTRL_WIDTH-1:0] <= ctrl;
        end
        SEL_STATUS: begin
          s_axi_rdata[`STAT_COUNT_LSB +: 4] <= count;
          s_axi_rdata[`STAT_LATCH_LSB +: 4] <= latched;
          s_axi_rdata[`STAT_MAXCNT_BIT]     <= max_count_n;
          s_axi_rdata[`STAT_NODE_BIT]       <= node_sync;
          s_axi_rdata[`STAT_SEG_LSB +: 7]   <= seg_link.seg_n;
          s_axi_rdata[`STAT_POINT_BIT]      <= seg_link.point_n;
        end
        default: begin
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Decade counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `COUNT_ZERO;
    end else if (!direct_clear_n) begin
      count <= `COUNT_ZERO;
    end else if (!parallel_count_enable_n && !serial_count_enable_n) begin
      if (count == `COUNT_MAX) begin
        count <= `COUNT_ZERO;
      end else begin
        count <= count + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Terminal count output
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      max_count_n <= 1'b1;
    end else begin
      max_count_n <= ~((count == `COUNT_MAX) & ~serial_count_enable_n);
    end
  end

  // ----------------------------------------------------------------
  // Output latch
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched <= `COUNT_ZERO;
    end else if (!hold_latch) begin
      latched <= count;
    end
  end

  assign bcd_out_weight1 = latched[0];
  assign bcd_out_weight2 = latched[1];
  assign bcd_out_weight4 = latched[2];
  assign bcd_out_weight8 = latched[3];

  // ----------------------------------------------------------------
  // Zero-blank node
  // ----------------------------------------------------------------
  assign zero_blank_out_n = ~(blank_all | ((latched == `COUNT_ZERO) & ~zero_blank_in_n));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_blank_node_n_drive <= 1'b0;
      zero_blank_node_n_oe    <= 1'b0;
    end else begin
      zero_blank_node_n_drive <= 1'b0;
      zero_blank_node_n_oe    <= ~zero_blank_out_n;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      node_meta <= 1'b1;
      node_sync <= 1'b1;
    end else begin
      node_meta <= zero_blank_node_n_level;
      node_sync <= node_meta;
    end
  end

  // ----------------------------------------------------------------
  // Display blanking
  // ----------------------------------------------------------------
  assign display_blank = ~zero_blank_out_n | ~node_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_q <= 1'b1;
    end else begin
      blank_q <= display_blank;
    end
  end

  // ----------------------------------------------------------------
  // Segment decoder
  // ----------------------------------------------------------------
  assign seg_link.value = latched;
  assign seg_link.blank = blank_q;
  assign seg_link.point = point_in;

  segment_decoder u_decoder (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link    (seg_link.decoder)
  );

  assign seg_n             = seg_link.seg_n;
  assign point_segment_out = seg_link.point_n;

endmodule : bcd_counter_latch_segment_driver

//--- dv/bcd_display_checker.sv
// Concurrent checks on the top ports of the BCD display driver.
// Assumes a bind from the bench top; one aclk domain.
`timescale 1ns/1ps
module bcd_display_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [6:0] seg_n,
  input wire logic       point_segment_out,
  input wire logic       bcd_out_weight1,
  input wire logic       bcd_out_weight2,
  input wire logic       bcd_out_weight4,
  input wire logic       bcd_out_weight8,
  input wire logic       max_count_n,
  input wire logic       zero_blank_node_n_level,
  input wire logic       zero_blank_node_n_drive,
  input wire logic       zero_blank_node_n_oe
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [6:0] SHAPE [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic [3:0] bcd;
  assign bcd = {bcd_out_weight8, bcd_out_weight4, bcd_out_weight2, bcd_out_weight1};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence node_low5;
    (!zero_blank_node_n_level) [*5];
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
  AST_NODE_BLANK: assert property (node_low5 |-> seg_n == 7'h7f && point_segment_out)
    else $error("node low but display lit");
  AST_DRIVE_DARK: assert property (zero_blank_node_n_oe |=> seg_n == 7'h7f && point_segment_out)
    else $error("node pulled but display lit");
  AST_POINT_LIT: assert property (!point_segment_out |-> !$past(zero_blank_node_n_oe))
    else $error("point lit while blanked");
  AST_SEG_DECODE: assert property (seg_n != 7'h7f |-> seg_n == ~SHAPE[$past(bcd)])
    else $error("segment pattern wrong");
  AST_MAX_HOLD: assert property (!max_count_n [*2] |-> bcd == 4'h9)
    else $error("terminal count away from nine");
  AST_DRIVE_LOW: assert property (zero_blank_node_n_oe |-> !zero_blank_node_n_drive)
    else $error("node driven high");
endmodule : bcd_display_checker

//--- dv/display_far_side.sv
// Far side model: wired-AND blanking node with pull-up, neighbour decade pull.
// Assumes the bench drives ext_pull_low for the adjacent decade.
`timescale 1ns/1ps
module display_far_side (
  input  wire logic oe,
  input  wire logic drive,
  input  wire logic ext_pull_low,
  output      logic level
);
  // Pull-up unless any party sinks the node
  assign level = ((oe && !drive) || ext_pull_low) ? 1'b0 : 1'b1;
endmodule : display_far_side

//--- dv/bcd_counter_latch_segment_driver_tb_top.sv
// Self-checking bench for the BCD display driver over AXI4-Lite.
// Assumes the checker and far side model are compiled first.
`timescale 1ns/1ps
module bcd_counter_latch_segment_driver_tb_top;
  localparam logic [6:0] SHAPE [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, point_segment_out, max_count_n;
  logic bcd_out_weight1, bcd_out_weight2, bcd_out_weight4, bcd_out_weight8, ext_pull;
  logic zero_blank_node_n_level, zero_blank_node_n_drive, zero_blank_node_n_oe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [6:0]  seg_n;
  logic [3:0]  cv;
  int          error_cnt, num_checks, b;

  bcd_counter_latch_segment_driver dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .seg_n(seg_n), .point_segment_out(point_segment_out),
    .bcd_out_weight1(bcd_out_weight1), .bcd_out_weight2(bcd_out_weight2), .bcd_out_weight4(bcd_out_weight4),
    .bcd_out_weight8(bcd_out_weight8), .max_count_n(max_count_n), .zero_blank_node_n_level(zero_blank_node_n_level),
    .zero_blank_node_n_drive(zero_blank_node_n_drive), .zero_blank_node_n_oe(zero_blank_node_n_oe));
  display_far_side far (.oe(zero_blank_node_n_oe), .drive(zero_blank_node_n_drive), .ext_pull_low(ext_pull),
    .level(zero_blank_node_n_level));

  always #5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Control changes only at a rising edge, clock high
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw = 1;
      if (s_axi_wvalid && s_axi_wready) w = 1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Clear, count for n cycles plus overhead, stop, read status
  task automatic run(input int n, input logic [31:0] go);
    wr(12'h000, 32'h21);
    wr(12'h000, go);
    repeat (n) @(posedge aclk);
    wr(12'h000, go | 32'h1);
    rd(12'h004);
  endtask : run

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #200us;
    error_cnt++;
    finish_test();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ext_pull} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000);
    check(rdat, 32'h27);
    rd(12'h004);
    check(rdat & 32'h1ff, 32'h100);
    run(0, 32'h24);
    b = rdat[3:0];
    for (int n = 1; n < 13; n++) begin
      run(n, 32'h24);
      cv = 4'((b + n) % 10);
      check(rdat & 32'h1ff, {23'h0, cv != 4'h9, cv, cv});
      check({bcd_out_weight8, bcd_out_weight4, bcd_out_weight2, bcd_out_weight1}, cv);
      check(seg_n, 7'(~SHAPE[cv]));
    end
    rd(12'h004);
    check(rdat[3:0], cv);
    run((19 - b) % 10, 32'h24);
    check(max_count_n, 1'b0);
    wr(12'h000, 32'h26);
    rd(12'h004);
    check(rdat & 32'h1ff, 32'h199);
    wr(12'h000, 32'h2c);
    repeat (3) @(posedge aclk);
    wr(12'h000, 32'h2d);
    rd(12'h004);
    cv = 4'((12 + b) % 10);
    check(rdat[7:0], {4'h9, cv});
    check({bcd_out_weight8, bcd_out_weight4, bcd_out_weight2, bcd_out_weight1}, 4'h9);
    wr(12'h000, 32'h25);
    rd(12'h004);
    check(rdat[7:0], {cv, cv});
    wr(12'h000, 32'h65);
    repeat (3) @(posedge aclk);
    check(point_segment_out, 1'b0);
    wr(12'h000, 32'h75);
    repeat (3) @(posedge aclk);
    check({zero_blank_node_n_oe, point_segment_out, seg_n}, 9'h1ff);
    rd(12'h004);
    check(rdat[9], 1'b0);
    wr(12'h000, 32'h65);
    repeat (6) @(posedge aclk);
    check(seg_n, 7'(~SHAPE[cv]));
    run((13 - b) % 10, 32'h04);
    repeat (8) @(posedge aclk);
    check({zero_blank_node_n_oe, seg_n}, {1'b0, ~SHAPE[3]});
    wr(12'h000, 32'h01);
    repeat (4) @(posedge aclk);
    check({zero_blank_node_n_oe, seg_n}, 8'hff);
    wr(12'h000, 32'h21);
    repeat (6) @(posedge aclk);
    check({zero_blank_node_n_oe, seg_n}, 8'h40);
    ext_pull <= 1'b1;
    repeat (6) @(posedge aclk);
    check(seg_n, 7'h7f);
    rd(12'h004);
    check(rdat[9], 1'b0);
    ext_pull <= 1'b0;
    repeat (6) @(posedge aclk);
    check(seg_n, 7'h40);
    wr(12'h010, 32'h0);
    check(resp, 2'b10);
    rd(12'h010);
    check(resp, 2'b10);
    check(rdat, 32'h0);
    wr(12'h004, 32'hff);
    check(resp, 2'b00);
    rd(12'h000);
    check(rdat, 32'h21);
    finish_test();
  end
endmodule : bcd_counter_latch_segment_driver_tb_top

bind bcd_counter_latch_segment_driver bcd_display_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .seg_n(seg_n),
  .point_segment_out(point_segment_out), .bcd_out_weight1(bcd_out_weight1), .bcd_out_weight2(bcd_out_weight2),
  .bcd_out_weight4(bcd_out_weight4), .bcd_out_weight8(bcd_out_weight8), .max_count_n(max_count_n),
  .zero_blank_node_n_level(zero_blank_node_n_level), .zero_blank_node_n_drive(zero_blank_node_n_drive),
  .zero_blank_node_n_oe(zero_blank_node_n_oe));
